//--- hw/bcre_pkg.sv
/*
  constants for the bit, carry and return execution slice of the 4-bit core:
  opcodes, widths, register offsets and reset values.
  assumes a 10-bit instruction word and word-aligned avalon byte offsets.
*/
package bcre_pkg;
  // widths of the core state this slice touches
  localparam int unsigned OP_W = 10;
  localparam int unsigned PC_W = 11;
  localparam int unsigned STACK_POINTER_W = 3;
  localparam int unsigned X_W = 4;
  localparam int unsigned Y_W = 4;
  localparam int unsigned Z_W = 2;
  localparam int unsigned DA_W = Z_W + X_W + Y_W;
  localparam int unsigned BUS_AW = 5;

  // opcodes
  localparam logic [OP_W-1:0] OP_ROT_RIGHT_CARRY = 10'h01D;
  localparam logic [OP_W-1:0] OP_MEM_BIT_CLEAR = 10'h04C; // low two bits carry j
  localparam logic [OP_W-1:0] OP_PORT_BIT_CLEAR = 10'h014;
  localparam logic [OP_W-1:0] OP_SUB_RETURN = 10'h044;
  localparam logic [OP_W-1:0] OP_SUB_RETURN_SKIP = 10'h045;
  localparam logic [OP_W-1:0] OP_ISR_RETURN = 10'h046;

  // register byte offsets
  localparam logic [BUS_AW-1:0] REG_ACCUM = 5'h00;
  localparam logic [BUS_AW-1:0] REG_POINTER = 5'h04;
  localparam logic [BUS_AW-1:0] REG_MEMDATA = 5'h08;
  localparam logic [BUS_AW-1:0] REG_STATUS = 5'h0C;
  localparam logic [BUS_AW-1:0] REG_DPORT = 5'h10;

  // field positions
  localparam int unsigned ACC_CARRY_POS = 4;
  localparam int unsigned ACC_B_POS = 8;
  localparam int unsigned PTR_X_POS = 4;
  localparam int unsigned PTR_Z_POS = 8;
  localparam int unsigned ST_SKIP_POS = 4;
  localparam int unsigned ST_PC_POS = 8;

  // reset values
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [3:0] DPORT_RST = 4'hF;
  localparam logic [STACK_POINTER_W-1:0] STACK_POINTER_RST = 3'h7;
  localparam logic [PC_W-1:0] PC_RST = 11'h000;

  typedef enum logic {RET_IDLE, RET_SECOND} bcre_ret_t;
endpackage

//--- hw/bcre_mem.sv
/*
  small synchronous memory with one write port and a registered read port.
  the read port follows the next read address, so its data always show the
  current word; a write to that word in the same cycle is passed through.
*/
`timescale 1ns/1ps
module bcre_mem #(
  parameter int unsigned DW = 4,
  parameter int unsigned AW = 3
) (
  input wire logic clk_sys_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];

  // write port and write-first read register
  always_ff @(posedge clk_sys_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    if (we_i && (waddr_i == raddr_i)) begin
      rdata_o <= wdata_i;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule

//--- hw/bcre_exec.sv
/*
  execution slice for rotate through carry, memory bit clear, port bit clear
  and the three returns of a 4-bit core, with an avalon-mm register slave.
  assumes the fetch logic on the same clock presents one instruction at a
  time, pushes return addresses through call or interrupt entry, and keeps
  the stack contents meaningful before any return.
*/
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
// Contract
// - rotate right through carry flag
// - clear bit j of memory at pointer
// - clear port line selected by y
// - return and skip, two cycles
// - interrupt return pops pc in one cycle
// - interrupt return restores saved processor state
`timescale 1ns/1ps
module bcre_exec (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic instr_valid_i,
  input wire logic [bcre_pkg::OP_W-1:0] instr_i,
  output logic instr_ready_o,
  input wire logic [bcre_pkg::PC_W-1:0] pc_i,
  input wire logic call_i,
  input wire logic int_entry_i,
  input wire logic skip_req_i,
  input wire logic nop_status_i,
  output logic [bcre_pkg::PC_W-1:0] pc_o,
  output logic pc_load_o,
  output logic skip_o,
  output logic nop_restore_o,
  output logic restore_o,
  output logic [3:0] d_port_o,
  input wire logic [bcre_pkg::BUS_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import bcre_pkg::*;

  typedef struct packed {
    logic [3:0] acc;
    logic carry;
    logic [3:0] b;
    logic [X_W-1:0] ptr_x;
    logic [Y_W-1:0] ptr_y;
    logic [Z_W-1:0] ptr_z;
    logic [STACK_POINTER_W-1:0] stack_pointer;
    logic [PC_W-1:0] pc;
    logic pc_load;
    logic skip;
    logic [3:0] dport;
    bcre_ret_t ret;
    logic ret_skip;
    logic [3:0] sh_acc;
    logic sh_carry;
    logic [3:0] sh_b;
    logic [X_W-1:0] sh_x;
    logic [Y_W-1:0] sh_y;
    logic [Z_W-1:0] sh_z;
    logic sh_skip;
    logic sh_nop;
    logic nop_restore;
    logic restore;
    logic rd_pend;
    logic [31:0] rdata;
  } bcre_state_t;

  bcre_state_t st;
  bcre_state_t next_st;
  logic [PC_W-1:0] stack_rdata;
  logic [3:0] mem_rdata;
  logic stack_we;
  logic [STACK_POINTER_W-1:0] stack_waddr;
  logic mem_we;
  logic [3:0] mem_wdata;
  logic take;
  logic bus_wr;

  // data memory address from z, x, y
  function automatic logic [DA_W-1:0] data_pointer_addr(input bcre_state_t s);
    return {s.ptr_z, s.ptr_x, s.ptr_y};
  endfunction

  // memory bit clear matches on all but the two bit-select bits
  function automatic logic is_bit_clear(input logic [OP_W-1:0] op);
    return op[OP_W-1:2] == OP_MEM_BIT_CLEAR[OP_W-1:2];
  endfunction

  // bus write wins the cycle; a return holds the fetch side for its second cycle
  assign bus_wr = avs_write;
  assign instr_ready_o = ~bus_wr & (st.ret == RET_IDLE);
  assign take = instr_valid_i & instr_ready_o;
  assign avs_waitrequest = avs_read & ~st.rd_pend;

  // next state
  always_comb begin
    next_st = st;
    next_st.pc_load = 1'b0;
    next_st.restore = 1'b0;
    next_st.rd_pend = 1'b0;
    stack_we = 1'b0;
    stack_waddr = st.stack_pointer;
    mem_we = 1'b0;
    mem_wdata = mem_rdata;
    // push of a return address, saving state on interrupt entry
    if (call_i || int_entry_i) begin
      next_st.stack_pointer = st.stack_pointer + 3'h1;
      stack_we = 1'b1;
      stack_waddr = st.stack_pointer + 3'h1;
    end
    if (int_entry_i) begin
      next_st.sh_acc = st.acc;
      next_st.sh_carry = st.carry;
      next_st.sh_b = st.b;
      next_st.sh_x = st.ptr_x;
      next_st.sh_y = st.ptr_y;
      next_st.sh_z = st.ptr_z;
      next_st.sh_skip = st.skip;
      next_st.sh_nop = nop_status_i;
    end
    // second cycle of a subroutine return
    if (st.ret == RET_SECOND) begin
      next_st.pc = stack_rdata;
      next_st.pc_load = 1'b1;
      next_st.stack_pointer = st.stack_pointer - 3'h1;
      next_st.skip = st.ret_skip;
      next_st.ret = RET_IDLE;
    end
    // one instruction, discarded when a skip is pending
    if (take && st.skip) begin
      next_st.skip = 1'b0;
    end else if (take) begin
      if (instr_i == OP_ROT_RIGHT_CARRY) begin
        next_st.acc = {st.carry, st.acc[3:1]};
        next_st.carry = st.acc[0];
      end else if (is_bit_clear(instr_i)) begin
        mem_we = 1'b1;
        mem_wdata = mem_rdata & ~(4'h1 << instr_i[1:0]);
      end else if (instr_i == OP_PORT_BIT_CLEAR) begin
        // only y bits 1:0 index the port; a larger y clears the line given by its low two bits
        next_st.dport[st.ptr_y[1:0]] = 1'b0;
      end else if (instr_i == OP_SUB_RETURN || instr_i == OP_SUB_RETURN_SKIP) begin
        next_st.ret = RET_SECOND;
        next_st.ret_skip = instr_i[0];
      end else if (instr_i == OP_ISR_RETURN) begin
        next_st.pc = stack_rdata;
        next_st.pc_load = 1'b1;
        next_st.stack_pointer = st.stack_pointer - 3'h1;
        next_st.acc = st.sh_acc;
        next_st.carry = st.sh_carry;
        next_st.b = st.sh_b;
        next_st.ptr_x = st.sh_x;
        next_st.ptr_y = st.sh_y;
        next_st.ptr_z = st.sh_z;
        next_st.skip = st.sh_skip;
        next_st.nop_restore = st.sh_nop;
        next_st.restore = 1'b1;
      end
    end
    // a skip raised by the fetch side wins over its own clearing
    if (skip_req_i) begin
      next_st.skip = 1'b1;
    end
    // register writes
    if (bus_wr) begin
      case (avs_address)
        REG_ACCUM: begin
          next_st.acc = avs_writedata[3:0];
          next_st.carry = avs_writedata[ACC_CARRY_POS];
          next_st.b = avs_writedata[ACC_B_POS +: 4];
        end
        REG_POINTER: begin
          next_st.ptr_y = avs_writedata[Y_W-1:0];
          next_st.ptr_x = avs_writedata[PTR_X_POS +: X_W];
          next_st.ptr_z = avs_writedata[PTR_Z_POS +: Z_W];
        end
        REG_MEMDATA: begin
          mem_we = 1'b1;
          mem_wdata = avs_writedata[3:0];
        end
        REG_DPORT: begin
          next_st.dport = avs_writedata[3:0];
        end
        default: begin
        end
      endcase
    end
    // register reads: capture in the first cycle, answer in the second
    if (avs_read && !st.rd_pend) begin
      next_st.rd_pend = 1'b1;
      case (avs_address)
        REG_ACCUM: next_st.rdata = {20'h0, st.b, 3'h0, st.carry, st.acc};
        REG_POINTER: next_st.rdata = {22'h0, st.ptr_z, st.ptr_x, st.ptr_y};
        REG_MEMDATA: next_st.rdata = {28'h0, mem_rdata};
        REG_STATUS: next_st.rdata = {13'h0, st.pc, 3'h0, st.skip, 1'b0, st.stack_pointer};
        REG_DPORT: next_st.rdata = {28'h0, st.dport};
        default: next_st.rdata = 32'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
      st.acc <= ACC_RST;
      st.stack_pointer <= STACK_POINTER_RST;
      st.pc <= PC_RST;
      st.dport <= DPORT_RST;
      st.ret <= RET_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // return stack
  bcre_mem #(.DW(PC_W), .AW(STACK_POINTER_W)) u_stack (
    .clk_sys_i(clk_sys_i),
    .we_i(stack_we),
    .waddr_i(stack_waddr),
    .wdata_i(pc_i),
    .raddr_i(next_st.stack_pointer),
    .rdata_o(stack_rdata)
  );

  // nibble data memory at the data pointer
  bcre_mem #(.DW(4), .AW(DA_W)) u_data (
    .clk_sys_i(clk_sys_i),
    .we_i(mem_we),
    .waddr_i(data_pointer_addr(st)),
    .wdata_i(mem_wdata),
    .raddr_i(data_pointer_addr(next_st)),
    .rdata_o(mem_rdata)
  );

  assign pc_o = st.pc;
  assign pc_load_o = st.pc_load;
  assign skip_o = st.skip;
  assign nop_restore_o = st.nop_restore;
  assign restore_o = st.restore;
  assign d_port_o = st.dport;
  assign avs_readdata = st.rdata;
endmodule

//--- verification/bcre_exec_props.sv
/* checker on the exec slice ports.
   assumes a bind from the bench top. */
`timescale 1ns/1ps
module bcre_exec_props (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic instr_valid_i,
  input wire logic [bcre_pkg::OP_W-1:0] instr_i,
  input wire logic instr_ready_o,
  input wire logic int_entry_i,
  input wire logic nop_status_i,
  input wire logic skip_req_i,
  input wire logic pc_load_o,
  input wire logic skip_o,
  input wire logic nop_restore_o,
  input wire logic restore_o,
  input wire logic [3:0] d_port_o
);
  import bcre_pkg::*;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  logic tk;
  logic nop_q;
  // an instruction that executes: taken and not skipped
  assign tk = instr_valid_i && instr_ready_o && !skip_o;
  // nop status saved at interrupt entry
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) nop_q <= 1'b0;
    else if (int_entry_i) nop_q <= nop_status_i;
  end
  ret_two_a: assert property (
    tk && instr_i == OP_SUB_RETURN |=> !instr_ready_o && !pc_load_o ##1 pc_load_o)
    else $error("return timing wrong");
  ret_skip_a: assert property (
    tk && instr_i == OP_SUB_RETURN_SKIP |-> ##2 pc_load_o && skip_o)
    else $error("return and skip wrong");
  skip_drop_a: assert property (
    instr_valid_i && instr_ready_o && skip_o && !skip_req_i |=> !skip_o)
    else $error("skip not consumed");
  isr_one_a: assert property (
    tk && instr_i == OP_ISR_RETURN |=> pc_load_o && restore_o)
    else $error("interrupt return not one cycle");
  restore_pair_a: assert property (
    restore_o |-> pc_load_o)
    else $error("restore without pc load");
  isr_nop_a: assert property (
    tk && instr_i == OP_ISR_RETURN |=> nop_restore_o == nop_q)
    else $error("nop status not restored");
  port_clr_a: assert property (
    tk && instr_i == OP_PORT_BIT_CLEAR |=> (d_port_o & ~$past(d_port_o)) == 4'h0)
    else $error("port clear raised a line");
  port_one_a: assert property (
    tk && instr_i == OP_PORT_BIT_CLEAR && d_port_o == 4'hF |=> $countones(d_port_o) == 3)
    else $error("port clear missed its line");
  skip_set_a: assert property (
    skip_req_i |=> skip_o)
    else $error("skip request lost");
endmodule

//--- verification/bcre_fetch_model.sv
/* fetch side model: offers opcodes with valid/ready and pulses pushes.
   assumes the bench calls its tasks from one process. */
`timescale 1ns/1ps
module bcre_fetch_model (
  input wire logic clk_sys_i,
  input wire logic ready_i,
  output logic valid_o,
  output logic [bcre_pkg::OP_W-1:0] instr_o,
  output logic [bcre_pkg::PC_W-1:0] pc_o,
  output logic call_o,
  output logic int_o,
  output logic nop_o
);
  import bcre_pkg::*;
  // idle data lines show the inverse of their last value; valid and the push strobes go low
  initial begin
    valid_o = 1'b0;
    instr_o = '1;
    pc_o = '1;
    call_o = 1'b0;
    int_o = 1'b0;
    nop_o = 1'b0;
  end
  // hold the opcode until the edge where ready is high
  task automatic issue(input logic [OP_W-1:0] op);
    @(posedge clk_sys_i);
    valid_o <= 1'b1;
    instr_o <= op;
    @(posedge clk_sys_i);
    while (!ready_i) @(posedge clk_sys_i);
    valid_o <= 1'b0;
    instr_o <= ~op;
  endtask
  // one-cycle call or interrupt entry push
  task automatic push(input logic [PC_W-1:0] pc, input logic isr, input logic ns);
    @(posedge clk_sys_i);
    pc_o <= pc;
    call_o <= !isr;
    int_o <= isr;
    nop_o <= ns;
    @(posedge clk_sys_i);
    call_o <= 1'b0;
    int_o <= 1'b0;
    pc_o <= ~pc;
    nop_o <= ~ns;
  endtask
endmodule

//--- verification/tb_bit_carry_return_exec.sv
/* bench for the exec slice: avalon tasks, a case table, returns.
   assumes the fetch model and checker files compile first. */
`timescale 1ns/1ps
module tb_bit_carry_return_exec;
  import bcre_pkg::*;
  typedef struct {
    logic [BUS_AW-1:0] pa;
    logic [31:0] pd;
    logic [OP_W-1:0] op;
    logic [BUS_AW-1:0] ca;
    logic [31:0] ex;
  } bcre_row_t;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic v, call, ie, nop, rdy, pl, skp, nr, rs, wt;
  logic [OP_W-1:0] ins;
  logic [PC_W-1:0] pci, pc;
  logic [3:0] dport;
  logic [BUS_AW-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic sreq = 1'b0;
  logic [31:0] wd = '0;
  logic [31:0] rdat, q;
  int error_cnt = 0;
  int compares = 0;
  // preset register, opcode, register read back, value expected
  bcre_row_t rows [10] = '{
    '{REG_POINTER, 32'h0, OP_PORT_BIT_CLEAR, REG_DPORT, 32'hE},
    '{REG_POINTER, 32'h1, OP_PORT_BIT_CLEAR, REG_DPORT, 32'hC},
    '{REG_POINTER, 32'h2, OP_PORT_BIT_CLEAR, REG_DPORT, 32'h8},
    '{REG_POINTER, 32'h3, OP_PORT_BIT_CLEAR, REG_DPORT, 32'h0},
    '{REG_MEMDATA, 32'hF, OP_MEM_BIT_CLEAR, REG_MEMDATA, 32'hE},
    '{REG_MEMDATA, 32'hF, OP_MEM_BIT_CLEAR + 10'h1, REG_MEMDATA, 32'hD},
    '{REG_MEMDATA, 32'hF, OP_MEM_BIT_CLEAR + 10'h2, REG_MEMDATA, 32'hB},
    '{REG_MEMDATA, 32'hF, OP_MEM_BIT_CLEAR + 10'h3, REG_MEMDATA, 32'h7},
    '{REG_ACCUM, 32'h315, OP_ROT_RIGHT_CARRY, REG_ACCUM, 32'h31A},
    '{REG_ACCUM, 32'h003, OP_ROT_RIGHT_CARRY, REG_ACCUM, 32'h011}};
  always #50 clk_sys_i = ~clk_sys_i;
  bcre_exec dut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .instr_valid_i(v), .instr_i(ins),
    .instr_ready_o(rdy), .pc_i(pci), .call_i(call), .int_entry_i(ie), .skip_req_i(sreq),
    .nop_status_i(nop), .pc_o(pc), .pc_load_o(pl), .skip_o(skp), .nop_restore_o(nr),
    .restore_o(rs), .d_port_o(dport), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt));
  bcre_fetch_model f (.clk_sys_i(clk_sys_i), .ready_i(rdy), .valid_o(v), .instr_o(ins),
    .pc_o(pci), .call_o(call), .int_o(ie), .nop_o(nop));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // avalon write and read, held until waitrequest is low
  task automatic bw(input logic [BUS_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    while (wt) @(posedge clk_sys_i);
    wr <= 1'b0;
    wd <= ~d;
  endtask
  task automatic br(input logic [BUS_AW-1:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    while (wt) @(posedge clk_sys_i);
    d = rdat;
    rd <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #200000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    br(REG_STATUS, q);
    chk(q, 32'h7);
    br(5'h14, q);
    chk(q, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      bw(rows[i].pa, rows[i].pd);
      f.issue(rows[i].op);
      br(rows[i].ca, q);
      chk(q, rows[i].ex);
    end
    $display("test table done");
    f.push(11'h155, 1'b0, 1'b0);
    f.push(11'h2AA, 1'b0, 1'b0);
    f.issue(OP_SUB_RETURN_SKIP);
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk({20'h0, skp, pc}, 32'hAAA);
    f.issue(OP_SUB_RETURN);
    f.issue(OP_SUB_RETURN);
    repeat (3) @(posedge clk_sys_i);
    br(REG_STATUS, q);
    chk(q, 32'h15507);
    $display("test returns done");
    bw(REG_ACCUM, 32'h715);
    bw(REG_POINTER, 32'h123);
    f.push(11'h0F0, 1'b1, 1'b1);
    bw(REG_ACCUM, 32'h0);
    bw(REG_POINTER, 32'h0);
    f.issue(OP_ISR_RETURN);
    repeat (2) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk({20'h0, nr, pc}, 32'h8F0);
    br(REG_ACCUM, q);
    chk(q, 32'h715);
    br(REG_POINTER, q);
    chk(q, 32'h123);
    br(REG_STATUS, q);
    chk(q, 32'hF007);
    $display("test interrupt return done");
    // a skip raised by the fetch side drops the next instruction
    bw(REG_ACCUM, 32'h5);
    @(posedge clk_sys_i);
    sreq <= 1'b1;
    @(posedge clk_sys_i);
    sreq <= 1'b0;
    f.issue(OP_ROT_RIGHT_CARRY);
    br(REG_ACCUM, q);
    chk(q, 32'h5);
    chk({31'h0, skp}, 32'h0);
    $display("test skip request done");
    // reset in mid-run brings back the reset values
    @(posedge clk_sys_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    chk({28'h0, dport}, {28'h0, DPORT_RST});
    rstn_i <= 1'b1;
    br(REG_ACCUM, q);
    chk(q, {28'h0, ACC_RST});
    br(REG_STATUS, q);
    chk(q, {13'h0, PC_RST, 5'h0, STACK_POINTER_RST});
    $display("test reset again done");
    give_verdict();
  end
endmodule
bind bcre_exec bcre_exec_props u_props (.clk_sys_i, .rstn_i, .instr_valid_i, .instr_i,
  .instr_ready_o, .int_entry_i, .nop_status_i, .skip_req_i, .pc_load_o, .skip_o,
  .nop_restore_o, .restore_o, .d_port_o);
